// >>> core/cev_exception_unit.sv
// How it works
// - Handlers are found via a 256-entry, 1024-byte table at a movable base.
// - First 64 entries are processor exceptions; the other 192 are user interrupts.
// - Each entry is one long word; reset uses two: stack then counter.
// - Reset fetches use supervisor program space; vector fetches and frame pushes supervisor data space.
// - Vector address is base plus the 8-bit number shifted left by two.
// - After reset, stack comes from offset 000 and counter from 004.
// - Vector 24 is spurious; 25 to 31 autovector levels one to seven.
// - Trap instructions 0 to 15 use vectors 32 to 47 from offset 080.
// - Vectors 64 to 255 from offset 100 are user defined.
// - Vectors 14 and 15 serve format error and uninitialized interrupt.
// - 13 is coprocessor violation; 16-23, 59-63 unassigned; 48-58 coprocessor.
// - Illegal opcodes, privilege, odd fetches and odd operands raise exceptions.
// - Non-reset exceptions copy status, set supervisor, clear both trace bits.
// - Reset and interrupts also update the interrupt priority mask.
// - Interrupt vectors come from an acknowledge cycle in space F.
// - A frame with status and program counter is pushed on supervisor stack.
// - Fetched vector loads the program counter; execution resumes if nothing pends.
// - Standby ends only on reset or an interrupt at or above stop level.
// - Single-instruction loop mode ends whenever any exception is taken.
`timescale 1ns/1ps
`default_nettype none
module cev_exception_unit (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        reset_req,
    input  wire logic        exc_bus_error,
    input  wire logic        exc_illegal,
    input  wire logic        exc_privilege,
    input  wire logic        exc_odd_fetch,
    input  wire logic        exc_odd_operand,
    input  wire logic        exc_zero_div,
    input  wire logic        exc_bounds,
    input  wire logic        exc_cond_call,
    input  wire logic        exc_trace,
    input  wire logic        exc_line_a,
    input  wire logic        exc_line_f,
    input  wire logic        exc_breakpoint,
    input  wire logic        exc_format,
    input  wire logic        exc_copro,
    input  wire logic        trap_req,
    input  wire logic [3:0]  trap_num,
    input  wire logic [2:0]  irq_level,
    input  wire logic        standby_halt_instr,
    input  wire logic [2:0]  standby_level,
    input  wire logic        base_write,
    input  wire logic [31:0] base_wdata,
    input  wire logic        status_write,
    input  wire logic [15:0] status_wdata,
    input  wire logic [31:0] cur_pc,
    input  wire logic [31:0] cur_ssp,
    input  wire logic        loop_enter,
    output logic             bus_req,
    output logic             bus_we,
    output logic [3:0]       bus_space,
    output logic [31:0]      bus_addr,
    output logic [31:0]      bus_wdata,
    input  wire logic        bus_done,
    input  wire logic [31:0] bus_rdata,
    input  wire logic        bus_err,
    output logic [31:0]      vector_table_base,
    output logic [15:0]      status_word,
    output logic [15:0]      saved_status,
    output logic [31:0]      new_pc,
    output logic [31:0]      new_ssp,
    output logic             pc_load,
    output logic             busy,
    output logic             standby,
    output logic             loop_mode,
    output logic             double_fault
);
    // --------
    // Bus port and address former
    // --------
    cev_bus_if bif ();

    cev_bus_port u_port (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .bus       (bif.slave),
        .bus_req   (bus_req),
        .bus_we    (bus_we),
        .bus_space (bus_space),
        .bus_addr  (bus_addr),
        .bus_wdata (bus_wdata),
        .bus_done  (bus_done),
        .bus_rdata (bus_rdata),
        .bus_err   (bus_err)
    );

    cev_pkg::cev_state_t state;
    logic [7:0]  vec_num;
    logic [31:0] vec_addr;
    logic [2:0]  irq_taken;
    logic [1:0]  push_idx;
    logic [31:0] frame_sp;

    cev_vec_addr u_addr (
        .table_base (vector_table_base),
        .vec_num    (vec_num),
        .vec_addr   (vec_addr)
    );

    // --------
    // Pending-source selection
    // --------
    logic       irq_hit;
    logic       any_exc;
    logic [7:0] int_vec;

    // Level 7 cannot be masked; lower levels must exceed the mask.
    assign irq_hit = (irq_level != 3'h0) &&
                     ((irq_level == 3'h7) ||
                      (irq_level > status_word[cev_pkg::SW_MASK_LSB +: 3]));

    always_comb begin
        any_exc = 1'b1;
        int_vec = cev_pkg::VEC_ILLEGAL;
        if (exc_bus_error) begin
            int_vec = cev_pkg::VEC_BUS_ERR;
        end else if (exc_odd_fetch || exc_odd_operand) begin
            int_vec = cev_pkg::VEC_ADDR_ERR;
        end else if (exc_illegal) begin
            int_vec = cev_pkg::VEC_ILLEGAL;
        end else if (exc_privilege) begin
            int_vec = cev_pkg::VEC_PRIV;
        end else if (exc_line_a) begin
            int_vec = cev_pkg::VEC_LINE_A;
        end else if (exc_line_f) begin
            int_vec = cev_pkg::VEC_LINE_F;
        end else if (exc_copro) begin
            int_vec = cev_pkg::VEC_COPRO_PROT;
        end else if (exc_format) begin
            int_vec = cev_pkg::VEC_FORMAT_ERR;
        end else if (exc_zero_div) begin
            int_vec = cev_pkg::VEC_ZERO_DIV;
        end else if (exc_bounds) begin
            int_vec = cev_pkg::VEC_BOUNDS;
        end else if (exc_cond_call) begin
            int_vec = cev_pkg::VEC_COND_CALL;
        end else if (trap_req) begin
            int_vec = cev_pkg::VEC_TRAP_BASE | {4'h0, trap_num};
        end else if (exc_breakpoint) begin
            int_vec = cev_pkg::VEC_HW_BREAK;
        end else if (exc_trace) begin
            int_vec = cev_pkg::VEC_TRACE;
        end else begin
            any_exc = 1'b0;
        end
    end

    // --------
    // Sequencer
    // --------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= cev_pkg::CEV_RST_SP;
            vec_num   <= cev_pkg::VEC_RESET_SP;
            irq_taken <= 3'h0;
            push_idx  <= 2'h0;
        end else if (reset_req) begin
            state   <= cev_pkg::CEV_RST_SP;
            vec_num <= cev_pkg::VEC_RESET_SP;
        end else begin
            unique case (state)
                cev_pkg::CEV_IDLE, cev_pkg::CEV_DONE: begin
                    push_idx <= 2'h0;
                    if (irq_hit) begin
                        state     <= cev_pkg::CEV_ACK;
                        irq_taken <= irq_level;
                    end else if (any_exc) begin
                        state   <= cev_pkg::CEV_PUSH;
                        vec_num <= int_vec;
                    end else if (standby_halt_instr) begin
                        state <= cev_pkg::CEV_STANDBY;
                    end else begin
                        state <= cev_pkg::CEV_IDLE;
                    end
                end
                cev_pkg::CEV_STANDBY: begin
                    // Besides reset, only an interrupt at or above the stop level wakes it.
                    if (irq_level != 3'h0 && irq_level >= standby_level) begin
                        state     <= cev_pkg::CEV_ACK;
                        irq_taken <= irq_level;
                    end
                end
                cev_pkg::CEV_RST_SP: begin
                    if (bif.done) begin
                        state   <= cev_pkg::CEV_RST_PC;
                        vec_num <= cev_pkg::VEC_RESET_PC;
                    end
                end
                cev_pkg::CEV_RST_PC: begin
                    if (bif.done) begin
                        state <= cev_pkg::CEV_DONE;
                    end
                end
                cev_pkg::CEV_ACK: begin
                    if (bif.done) begin
                        // A bus error on acknowledge means spurious.
                        vec_num <= bif.err ? cev_pkg::VEC_SPURIOUS : bus_rdata[7:0];
                        state   <= cev_pkg::CEV_PUSH;
                    end
                end
                cev_pkg::CEV_PUSH: begin
                    if (bif.done) begin
                        push_idx <= push_idx + 2'h1;
                        if (push_idx == 2'(cev_pkg::FRAME_WORDS - 3'h1)) begin
                            state <= cev_pkg::CEV_FETCH;
                        end
                    end
                end
                cev_pkg::CEV_FETCH: begin
                    if (bif.done) begin
                        state <= cev_pkg::CEV_DONE;
                    end
                end
            endcase
        end
    end

    // --------
    // Bus request forming
    // --------
    always_comb begin
        bif.req   = 1'b0;
        bif.we    = 1'b0;
        bif.space = cev_pkg::SPACE_SUP_DATA;
        bif.addr  = vec_addr;
        bif.wdata = 32'h0;
        unique case (state)
            cev_pkg::CEV_RST_SP: begin
                bif.req   = 1'b1;
                bif.space = cev_pkg::SPACE_SUP_PROG;
                bif.addr  = cev_pkg::OFF_RESET_SP;
            end
            cev_pkg::CEV_RST_PC: begin
                bif.req   = 1'b1;
                bif.space = cev_pkg::SPACE_SUP_PROG;
                bif.addr  = cev_pkg::OFF_RESET_PC;
            end
            cev_pkg::CEV_ACK: begin
                bif.req   = 1'b1;
                bif.space = cev_pkg::SPACE_CPU;
                bif.addr  = {28'h0, irq_taken, 1'b1};
            end
            cev_pkg::CEV_PUSH: begin
                // Frame: vector offset word, program counter, saved status.
                bif.req  = 1'b1;
                bif.we   = 1'b1;
                bif.addr = frame_sp - {28'h0, push_idx, 2'h0} - 32'h4;
                unique case (push_idx)
                    2'h0:    bif.wdata = {22'h0, vec_num, 2'h0};
                    2'h1:    bif.wdata = cur_pc;
                    default: bif.wdata = {16'h0, saved_status};
                endcase
            end
            cev_pkg::CEV_FETCH: begin
                bif.req   = 1'b1;
                bif.space = cev_pkg::SPACE_SUP_DATA;
                bif.addr  = vec_addr;
            end
            default: begin
                bif.req = 1'b0;
            end
        endcase
    end

    // --------
    // Status word and table base
    // --------
    logic starting;
    assign starting = ((state == cev_pkg::CEV_IDLE || state == cev_pkg::CEV_DONE) &&
                       (irq_hit || any_exc)) ||
                      (state == cev_pkg::CEV_STANDBY && irq_level != 3'h0 &&
                       irq_level >= standby_level);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_word  <= cev_pkg::STATUS_RESET;
            saved_status <= 16'h0;
            frame_sp     <= 32'h0;
        end else if (reset_req) begin
            status_word <= cev_pkg::STATUS_RESET;
        end else if (starting) begin
            saved_status                        <= status_word;
            frame_sp                            <= cur_ssp;
            status_word[cev_pkg::SW_SUPER]      <= 1'b1;
            status_word[cev_pkg::SW_TRACE_HIGH] <= 1'b0;
            status_word[cev_pkg::SW_TRACE_LOW]  <= 1'b0;
            if (irq_hit || state == cev_pkg::CEV_STANDBY) begin
                status_word[cev_pkg::SW_MASK_LSB +: 3] <= irq_level;
            end
        end else if (status_write && state == cev_pkg::CEV_IDLE) begin
            status_word <= status_wdata;
        end
    end

    // Relocation is allowed at any time, even during a running sequence.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            vector_table_base <= cev_pkg::BASE_RESET;
        end else if (reset_req) begin
            vector_table_base <= cev_pkg::BASE_RESET;
        end else if (base_write) begin
            vector_table_base <= base_wdata;
        end
    end

    // --------
    // Results to the core
    // --------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            new_pc       <= 32'h0;
            new_ssp      <= 32'h0;
            pc_load      <= 1'b0;
            busy         <= 1'b1;
            standby      <= 1'b0;
            loop_mode    <= 1'b0;
            double_fault <= 1'b0;
        end else begin
            pc_load <= 1'b0;
            if (bif.done && state == cev_pkg::CEV_RST_SP) begin
                new_ssp <= bus_rdata;
            end
            if (bif.done && (state == cev_pkg::CEV_RST_PC || state == cev_pkg::CEV_FETCH)) begin
                new_pc  <= bus_rdata;
                pc_load <= 1'b1;
            end
            if (state == cev_pkg::CEV_PUSH) begin
                new_ssp <= frame_sp - 32'hc;
            end
            busy    <= (state != cev_pkg::CEV_IDLE && state != cev_pkg::CEV_DONE &&
                        state != cev_pkg::CEV_STANDBY) || starting;
            standby <= (state == cev_pkg::CEV_STANDBY) && !starting && !reset_req;
            // Loop mode cannot survive any exception entry.
            if (starting || reset_req) begin
                loop_mode <= 1'b0;
            end else if (loop_enter) begin
                loop_mode <= 1'b1;
            end
            if (bif.done && bif.err && state == cev_pkg::CEV_PUSH) begin
                double_fault <= 1'b1;
            end else if (reset_req) begin
                double_fault <= 1'b0;
            end
        end
    end

    // Vectors 16-23 and 48-255 arrive only as numbers from an interrupter.
endmodule // cev_exception_unit
`default_nettype wire

// >>> common/cev_pkg.sv
package cev_pkg;

    // --------
    // Table geometry
    // --------
    localparam int unsigned TABLE_ENTRIES = 256;
    localparam int unsigned TABLE_BYTES   = 1024;
    localparam int unsigned VEC_SHIFT     = 2;

    // --------
    // Vector numbers
    // --------
    localparam logic [7:0] VEC_RESET_SP     = 8'h00;
    localparam logic [7:0] VEC_RESET_PC     = 8'h01;
    localparam logic [7:0] VEC_BUS_ERR      = 8'h02;
    localparam logic [7:0] VEC_ADDR_ERR     = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL      = 8'h04;
    localparam logic [7:0] VEC_ZERO_DIV     = 8'h05;
    localparam logic [7:0] VEC_BOUNDS       = 8'h06;
    localparam logic [7:0] VEC_COND_CALL    = 8'h07;
    localparam logic [7:0] VEC_PRIV         = 8'h08;
    localparam logic [7:0] VEC_TRACE        = 8'h09;
    localparam logic [7:0] VEC_LINE_A       = 8'h0a;
    localparam logic [7:0] VEC_LINE_F       = 8'h0b;
    localparam logic [7:0] VEC_HW_BREAK     = 8'h0c;
    localparam logic [7:0] VEC_COPRO_PROT   = 8'h0d;
    localparam logic [7:0] VEC_FORMAT_ERR   = 8'h0e;
    localparam logic [7:0] VEC_UNINIT_INT   = 8'h0f;
    localparam logic [7:0] VEC_SPURIOUS     = 8'h18;
    localparam logic [7:0] VEC_AUTO_BASE    = 8'h18;
    localparam logic [7:0] VEC_TRAP_BASE    = 8'h20;
    localparam logic [7:0] VEC_USER_FIRST   = 8'h40;

    // --------
    // Fixed reset and table offsets and reset values
    // --------
    localparam logic [31:0] OFF_RESET_SP    = 32'h0000_0000;
    localparam logic [31:0] OFF_RESET_PC    = 32'h0000_0004;
    localparam logic [31:0] OFF_TRAP_BASE   = 32'h0000_0080;
    localparam logic [31:0] OFF_USER_BASE   = 32'h0000_0100;
    localparam logic [31:0] BASE_RESET      = 32'h0000_0000;
    localparam logic [15:0] STATUS_RESET    = 16'h2700;
    localparam logic [2:0]  MASK_RESET      = 3'h7;

    // --------
    // Status word fields
    // --------
    localparam int unsigned SW_TRACE_HIGH   = 15;
    localparam int unsigned SW_TRACE_LOW    = 14;
    localparam int unsigned SW_SUPER        = 13;
    localparam int unsigned SW_MASK_LSB     = 8;

    // --------
    // Bus spaces and frame
    // --------
    localparam logic [3:0] SPACE_SUP_DATA   = 4'h5;
    localparam logic [3:0] SPACE_SUP_PROG   = 4'h6;
    localparam logic [3:0] SPACE_CPU        = 4'hf;
    localparam logic [2:0] FRAME_WORDS      = 3'h3;

    typedef enum logic [3:0] {
        CEV_IDLE     = 4'b0000,
        CEV_RST_SP   = 4'b0001,
        CEV_RST_PC   = 4'b0010,
        CEV_ACK      = 4'b0011,
        CEV_PUSH     = 4'b0100,
        CEV_FETCH    = 4'b0101,
        CEV_STANDBY  = 4'b0110,
        CEV_DONE     = 4'b0111
    } cev_state_t;

endpackage

// >>> common/cev_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cev_bus_if;
    logic        req;
    logic        we;
    logic [3:0]  space;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        done;
    logic [31:0] rdata;
    logic        err;

    modport master (output req, output we, output space, output addr, output wdata,
                    input done, input rdata, input err);
    modport slave  (input req, input we, input space, input addr, input wdata,
                    output done, output rdata, output err);
endinterface
`default_nettype wire

// >>> core/cev_vec_addr.sv
`timescale 1ns/1ps
`default_nettype none
module cev_vec_addr (
    input  wire logic [31:0] table_base,
    input  wire logic [7:0]  vec_num,
    output logic      [31:0] vec_addr
);
    // Offsets run 0 to 3fc, so the table spans exactly its 1024 bytes.
    assign vec_addr = table_base + {22'h0, vec_num, 2'h0};
endmodule // cev_vec_addr
`default_nettype wire

// >>> core/cev_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
module cev_bus_port (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    cev_bus_if.slave         bus,
    output logic             bus_req,
    output logic             bus_we,
    output logic [3:0]       bus_space,
    output logic [31:0]      bus_addr,
    output logic [31:0]      bus_wdata,
    input  wire logic        bus_done,
    input  wire logic [31:0] bus_rdata,
    input  wire logic        bus_err
);
    // --------
    // Registered bus pins
    // --------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_req   <= 1'b0;
            bus_we    <= 1'b0;
            bus_space <= 4'h0;
            bus_addr  <= 32'h0;
            bus_wdata <= 32'h0;
        end else begin
            bus_req   <= bus.req & ~bus_done;
            bus_we    <= bus.we;
            bus_space <= bus.space;
            bus_addr  <= bus.addr;
            bus_wdata <= bus.wdata;
        end
    end

    assign bus.done  = bus_done & bus_req;
    assign bus.rdata = bus_rdata;
    assign bus.err   = bus_err;
endmodule // cev_bus_port
`default_nettype wire

// >>> testbench/cev_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cev_monitor (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        bus_req,
    input wire logic        bus_we,
    input wire logic [3:0]  bus_space,
    input wire logic [31:0] bus_addr,
    input wire logic        bus_done,
    input wire logic [31:0] bus_rdata,
    input wire logic [31:0] vector_table_base,
    input wire logic [15:0] status_word,
    input wire logic [31:0] new_pc,
    input wire logic        pc_load,
    input wire logic        standby,
    input wire logic        loop_mode,
    input wire logic [2:0]  irq_level,
    input wire logic [2:0]  standby_level,
    input wire logic        reset_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_reset_offsets: assert property (
        bus_req && bus_space == cev_pkg::SPACE_SUP_PROG |-> (bus_addr & 32'hffff_fffb) == 32'h0)
        else $error("reset fetch address wrong");
    a_vector_window: assert property (
        bus_req && !bus_we && bus_space == cev_pkg::SPACE_SUP_DATA
        |-> bus_addr - vector_table_base < 32'h400 && bus_addr[1:0] == 2'h0) else $error("bad fetch");
    a_push_space: assert property (
        bus_req && bus_we |-> bus_space == cev_pkg::SPACE_SUP_DATA) else $error("push space wrong");
    a_ack_then_push: assert property (
        bus_done && bus_space == cev_pkg::SPACE_CPU |-> !bus_we ##[1:6] bus_req && bus_we)
        else $error("no push after acknowledge");
    a_pc_from_fetch: assert property (
        bus_req && bus_done && !bus_we && bus_space == cev_pkg::SPACE_SUP_DATA
        |=> pc_load && new_pc == $past(bus_rdata)) else $error("counter not loaded");
    a_super_state: assert property (
        bus_req && bus_space == cev_pkg::SPACE_SUP_DATA |-> status_word[15:13] == 3'b001)
        else $error("status not supervisor");
    a_standby_hold: assert property (
        standby && !reset_req && irq_level < standby_level |=> standby) else $error("left standby");
    a_loop_exit: assert property (
        bus_req |-> !loop_mode) else $error("loop mode kept");
endmodule // cev_monitor
bind cev_exception_unit cev_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus_req(bus_req), .bus_we(bus_we), .bus_space(bus_space), .bus_addr(bus_addr),
    .bus_done(bus_done), .bus_rdata(bus_rdata), .vector_table_base(vector_table_base),
    .status_word(status_word), .new_pc(new_pc), .pc_load(pc_load), .standby(standby),
    .loop_mode(loop_mode), .irq_level(irq_level), .standby_level(standby_level),
    .reset_req(reset_req));
`default_nettype wire

// >>> testbench/cev_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cev_bus_model (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        bus_req,
    input  wire logic [3:0]  bus_space,
    input  wire logic [31:0] bus_addr,
    input  wire logic        slow,
    input  wire logic [7:0]  ack_vec,
    input  wire logic        ack_err,
    output logic             bus_done,
    output logic [31:0]      bus_rdata,
    output logic             bus_err
);
    logic [1:0] wait_cnt;
    logic       hold;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_done <= 1'b0;
            bus_err <= 1'b0;
            hold <= 1'b0;
            wait_cnt <= 2'h0;
            bus_rdata <= 32'h0;
        end else begin
            bus_done <= 1'b0;
            bus_err <= 1'b0;
            // Released data is inverted so a stale value never passes for an answer.
            bus_rdata <= ~bus_rdata;
            if (!bus_req) hold <= 1'b0;
            if (bus_req && !bus_done && !hold) begin
                wait_cnt <= wait_cnt + 2'h1;
                if (!slow || wait_cnt == 2'h3) begin
                    bus_done <= 1'b1;
                    hold <= 1'b1;
                    wait_cnt <= 2'h0;
                    bus_err <= ack_err && bus_space == cev_pkg::SPACE_CPU;
                    bus_rdata <= (bus_space == cev_pkg::SPACE_CPU) ? {24'h0, ack_vec}
                                 : bus_addr + 32'h1000_0000;
                end
            end
        end
    end
endmodule // cev_bus_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        sys_clk, reset_n, reset_req, trap_req, standby_halt_instr, base_write, slow;
    logic        status_write, loop_enter, ack_err, bus_req, bus_we, bus_done, bus_err;
    logic        pc_load, standby, loop_mode;
    logic [13:0] exc;
    logic [3:0]  trap_num, bus_space;
    logic [2:0]  irq_level, standby_level;
    logic [7:0]  ack_vec;
    logic [7:0]  vecs [14] = '{8'd2, 8'd3, 8'd3, 8'd4, 8'd8, 8'd10, 8'd11, 8'd13, 8'd14, 8'd5,
                               8'd6, 8'd7, 8'd12, 8'd9};
    logic [15:0] status_wdata, status_word, saved_status;
    logic [31:0] base_wdata, bus_addr, bus_rdata, vector_table_base, new_pc, new_ssp, fetch_addr;
    logic [31:0] base, exp_addr, pushed_pc, bus_wdata;
    logic [31:0] cur_pc = 32'h0000_2000;
    logic [31:0] cur_ssp = 32'h0000_8000;
    int          n_errors = 0;
    int          comparisons = 0;
    cev_exception_unit u_dut (.*, .exc_bus_error(exc[0]), .exc_odd_fetch(exc[1]),
        .exc_odd_operand(exc[2]), .exc_illegal(exc[3]), .exc_privilege(exc[4]),
        .exc_line_a(exc[5]), .exc_line_f(exc[6]), .exc_copro(exc[7]), .exc_format(exc[8]),
        .exc_zero_div(exc[9]), .exc_bounds(exc[10]), .exc_cond_call(exc[11]),
        .exc_breakpoint(exc[12]), .exc_trace(exc[13]), .busy(), .double_fault());
    cev_bus_model u_bus (.*);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (bus_req && bus_done && !bus_we) fetch_addr <= bus_addr;
    always @(posedge sys_clk)
        if (bus_done && bus_we && bus_addr[3:0] == 4'h8) pushed_pc <= bus_wdata;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_load();
        repeat (200) begin
            @(posedge sys_clk);
            #1;
            if (pc_load === 1'b1) break;
        end
        check("pc load", {31'h0, pc_load}, 32'h1);
    endtask
    task automatic run(input logic [13:0] e, input logic [4:0] t, input logic [2:0] lv,
                       input logic [7:0] vec);
        @(posedge sys_clk);
        status_wdata <= 16'hc300;
        status_write <= 1'b1;
        @(posedge sys_clk);
        status_write <= 1'b0;
        exc <= e;
        {trap_req, trap_num} <= t;
        irq_level <= lv;
        @(posedge sys_clk);
        exc <= 14'h0;
        trap_req <= 1'b0;
        wait_load();
        exp_addr = base + {22'h0, vec, 2'b00};
        check("vector address", fetch_addr, exp_addr);
        check("new pc", new_pc, exp_addr + 32'h1000_0000);
        check("status", {16'h0, status_word}, {19'h1, 2'h0, (lv != 3'h0) ? lv : 3'h3, 8'h0});
        check("saved status", {16'h0, saved_status}, 32'h0000_c300);
        check("pushed pc", pushed_pc, cur_pc);
        check("loop mode", {31'h0, loop_mode}, 32'h0);
        @(posedge sys_clk);
        irq_level <= 3'h0;
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        {reset_req, exc, trap_req, trap_num, irq_level, standby_halt_instr, standby_level} = '0;
        {base_write, base_wdata, status_write, status_wdata, loop_enter, slow, ack_vec} = '0;
        {ack_err, base} = '0;
        reset_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            wait_load();
            check("reset pc", new_pc, 32'h1000_0004);
            check("reset sp", new_ssp, 32'h1000_0000);
            check("reset status", {16'h0, status_word}, 32'h0000_2700);
            check("standby", {31'h0, standby}, 32'h0);
            @(posedge sys_clk);
            {standby_level, irq_level, standby_halt_instr} <= {3'h5, 3'h4, 1'b1};
            repeat (6) @(posedge sys_clk);
            #1;
            check("standby", {31'h0, standby}, 32'h1);
            @(posedge sys_clk);
            {standby_halt_instr, reset_req} <= 2'b01;
            @(posedge sys_clk);
            {reset_req, irq_level} <= 4'h0;
        end
        wait_load();
        base = 32'h0000_4000;
        @(posedge sys_clk);
        {base_write, base_wdata, loop_enter} <= {1'b1, base, 1'b1};
        @(posedge sys_clk);
        {base_write, loop_enter} <= 2'b00;
        @(posedge sys_clk);
        #1;
        check("table base", vector_table_base, base);
        check("loop mode", {31'h0, loop_mode}, 32'h1);
        for (int i = 0; i < 14; i++) begin
            slow <= i[0];
            run(14'h1 << i, 5'h0, 3'h0, vecs[i]);
        end
        run(14'h0, 5'h10, 3'h0, 8'd32);
        run(14'h0, 5'h1f, 3'h0, 8'd47);
        ack_vec <= 8'h40;
        run(14'h0, 5'h0, 3'h4, 8'h40);
        ack_vec <= 8'hff;
        run(14'h0, 5'h0, 3'h5, 8'hff);
        ack_err <= 1'b1;
        run(14'h0, 5'h0, 3'h6, 8'd24);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
